//--- dv/dbrw_ctrl_model.sv
// Behavioural memory controller driving clock, commands, write strobe and write data.
`timescale 1ns/100ps
module dbrw_ctrl_model (
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [dbrw_pkg::BANK_W-1:0] ba,
  output logic [dbrw_pkg::ADDR_W-1:0] addr,
  output logic [dbrw_pkg::DQ_W-1:0] dq_in,
  output logic dqs_in,
  output logic [dbrw_pkg::LANES-1:0] mask,
  input wire logic [dbrw_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe
);
  import dbrw_pkg::*;
  logic [DQ_W-1:0] wdq;
  logic wdqs;
  logic wdrive;
  // Released pins follow the clock, so a stale value can never pass for data.
  assign dq_in = dq_oe ? dq_out : (wdrive ? wdq : {8{ck, ~ck}});
  assign dqs_in = dqs_oe ? dqs_out : (wdrive ? wdqs : ~ck);
  initial begin
    ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = CMD_IDLE;
    ba = 3'h0;
    addr = 14'h0000;
    wdq = 16'h0000;
    wdqs = 1'b0;
    wdrive = 1'b0;
    mask = 2'h3;
    #1013;
    forever #100 ck = ~ck;
  end
  ////////////////////////////////////////
  // Only mode, read and write commands are sent, each after the last burst ends.
  task automatic cmd(input logic [3:0] code, input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = code;
    ba = bank;
    addr = a;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = CMD_IDLE;
    addr = ~a;
  endtask
  task automatic write(input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] a, input int edges,
                       input logic [DQ_W-1:0] d [8], input logic [LANES-1:0] m [8]);
    cmd(CMD_WRITE, bank, a);
    repeat (3) @(posedge ck);
    @(negedge ck);
    wdrive = 1'b1;
    wdqs = 1'b0;
    wdq = d[0];
    mask = m[0];
    for (int i = 0; i < edges; i++) begin
      if (i % 2 == 0) @(posedge ck);
      else @(negedge ck);
      #20 wdqs = ~wdqs;
      #50 wdq = d[(i + 1) % 8];
      mask = m[(i + 1) % 8];
    end
    @(posedge ck);
    wdrive = 1'b0;
    mask = 2'h3;
  endtask
endmodule

//--- dv/dbrw_tb_top.sv
// Self-checking bench for the burst read and write engine.
`timescale 1ns/100ps
module dbrw_tb_top;
  import dbrw_pkg::*;
  localparam int LIMIT = 20000;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ck, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_in, dqs_out, dqs_oe;
  logic ck_q = 1'b0;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic [LANES-1:0] mask;
  logic [DQ_W-1:0] ref_mem [MEM_DEPTH];
  logic [DQ_W-1:0] wd [8];
  logic [LANES-1:0] wm [8];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int ck_rises = 0;
  always #12.5 clock = ~clock;
  always @(negedge clock) begin
    ck_q <= ck;
    if (ck && !ck_q) ck_rises <= ck_rises + 1;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      summarize();
    end
  end
  dbrw_top dbrw_top_inst (
    .CLOCK(clock), .RESET(reset), .CK(ck), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba),
    .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .DQS_IN(dqs_in), .DQS_OUT(dqs_out),
    .DQS_OE(dqs_oe), .WRITE_BYTE_MASK(mask)
  );
  dbrw_ctrl_model dbrw_ctrl_model_inst (
    .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .dqs_in(dqs_in), .mask(mask), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe)
  );
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [BANK_W-1:0] bank, input logic [COL_W-1:0] col, input int beats, input int edges);
    logic [COL_W-1:0] wrap;
    logic [COL_W-1:0] c;
    wrap = (beats == 8) ? 10'h007 : 10'h003;
    dbrw_ctrl_model_inst.write(bank, {1'b0, (beats == 8), 2'h0, col}, edges, wd, wm);
    for (int i = 0; i < beats; i++) begin
      c = (col & ~wrap) | ((col + 10'(i)) & wrap);
      for (int b = 0; b < LANES; b++) begin
        if (!wm[i][b]) ref_mem[{bank, c}][8 * b +: 8] = wd[i][8 * b +: 8];
      end
    end
  endtask
  // Latency is counted in link clock rises seen since the command rise.
  task automatic rd(input logic [BANK_W-1:0] bank, input logic [COL_W-1:0] col, input logic sel, input int beats,
                    input int lat);
    int n0;
    int k;
    int t;
    logic prev;
    logic [COL_W-1:0] wrap;
    logic [COL_W-1:0] c;
    wrap = (beats == 8) ? 10'h007 : 10'h003;
    k = 0;
    t = 0;
    prev = 1'b0;
    dbrw_ctrl_model_inst.cmd(CMD_READ, bank, {1'b0, sel, 2'h1, col});
    n0 = ck_rises;
    while (dqs_oe !== 1'b1 && t < 400) begin
      @(negedge clock);
      t++;
    end
    chk("read latency", ck_rises - n0, lat);
    while (dqs_oe === 1'b1 && t < 800) begin
      if (dqs_out !== prev) begin
        c = (col & ~wrap) | ((col + 10'(k)) & wrap);
        chk("read beat", dq_out, ref_mem[{bank, c}]);
        k++;
      end
      prev = dqs_out;
      @(negedge clock);
      t++;
    end
    chk("beat count", k, beats);
    chk("release rise", ck_rises - n0, lat + beats / 2);
  endtask
  task automatic t_burst_select();
    for (int i = 0; i < 8; i++) begin
      wd[i] = {4'ha, 4'(i), 4'h5, 4'(i)};
      wm[i] = 2'h0;
    end
    wr(3'h2, 10'h010, 8, 8);
    for (int i = 0; i < 8; i++) begin
      wd[i] = {4'hc, 4'(i), 4'h3, 4'(i)};
    end
    wm[1] = 2'h1;
    wm[2] = 2'h2;
    wr(3'h2, 10'h011, 4, 4);
    rd(3'h2, 10'h013, 1'b1, 8, 5);
    rd(3'h2, 10'h012, 1'b0, 4, 5);
    $display("test burst_select done");
  endtask
  task automatic t_modes();
    dbrw_ctrl_model_inst.cmd(CMD_MRS, BANK_MODE_ZERO, 14'h0012);
    rd(3'h2, 10'h010, 1'b1, 4, 6);
    dbrw_ctrl_model_inst.cmd(CMD_MRS, BANK_MODE_ONE, 14'h0008);
    dbrw_ctrl_model_inst.cmd(CMD_MRS, BANK_MODE_ZERO, 14'h0011);
    rd(3'h2, 10'h014, 1'b1, 8, 11);
    rd(3'h2, 10'h016, 1'b0, 4, 11);
    dbrw_ctrl_model_inst.cmd(CMD_MRS, BANK_MODE_ONE, 14'h0000);
    dbrw_ctrl_model_inst.cmd(CMD_MRS, BANK_MODE_ZERO, 14'h0000);
    $display("test modes done");
  endtask
  task automatic t_violation();
    foreach (wm[i]) wm[i] = 2'h0;
    wr(3'h5, 10'h040, 8, 3);
    // A controller that broke write timing reinitialises; stored data survives.
    @(negedge clock);
    reset = 1'b1;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    rd(3'h2, 10'h010, 1'b1, 8, 5);
    wr(3'h5, 10'h048, 4, 4);
    rd(3'h5, 10'h048, 1'b0, 4, 5);
    $display("test violation done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    t_burst_select();
    t_modes();
    t_violation();
    summarize();
  end
endmodule

//--- dv/dbrw_top_asserts.sv
// Concurrent checks on the read strobe and data pins of the burst engine.
`timescale 1ns/100ps
module dbrw_top_asserts (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CK,
  input wire logic [dbrw_pkg::DQ_W-1:0] DQ_OUT,
  input wire logic DQ_OE,
  input wire logic DQS_OUT,
  input wire logic DQS_OE
);
  import dbrw_pkg::*;
  logic dqs_q;
  logic [4:0] rise_cnt;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  always_ff @(posedge CLOCK) begin
    dqs_q <= DQS_OUT;
    if (RESET || !DQS_OE) begin
      rise_cnt <= 5'h00;
    end else if (DQS_OUT && !dqs_q) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end
  ////////////////////////////////////////
  // The link clock reaches the pins two or three cycles late, well inside its four-cycle half period.
  sequence burst_open;
    !$past(RESET) && $rose(DQS_OE);
  endsequence
  sequence burst_close;
    !$past(RESET) && $fell(DQS_OE);
  endsequence
  a_reset_quiet: assert property ($fell(RESET) |-> !DQ_OE && !DQS_OE && !DQS_OUT && DQ_OUT == {DQ_W{1'b0}})
    else $error("outputs busy after reset");
  a_oe_paired: assert property (DQ_OE == DQS_OE)
    else $error("data and strobe enables differ");
  a_burst_starts_high: assert property (burst_open |-> DQS_OUT)
    else $error("burst began on a low strobe");
  a_burst_min_len: assert property (burst_open |-> DQS_OE [*8] ##1 DQS_OE [*6])
    else $error("burst released too early");
  a_rise_on_ck: assert property (DQS_OE && $rose(DQS_OUT) |-> $past(CK))
    else $error("strobe rose away from a clock rise");
  a_fall_on_ck: assert property (DQS_OE && $fell(DQS_OUT) |-> !$past(CK))
    else $error("strobe fell away from a clock fall");
  a_release_on_rise: assert property (burst_close |-> $past(CK) && !DQS_OUT)
    else $error("release not at a clock rise");
  a_data_with_strobe: assert property (DQ_OE && $past(DQ_OE) && !$stable(DQ_OUT) |-> !$stable(DQS_OUT))
    else $error("data moved without a strobe edge");
  a_count_even: assert property (burst_close |-> rise_cnt != 5'h00 && !rise_cnt[0])
    else $error("burst ended with a partial beat pair");
endmodule
bind dbrw_top dbrw_top_asserts dbrw_top_asserts_inst (
  .CLOCK(CLOCK), .RESET(RESET), .CK(CK), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQS_OUT(DQS_OUT), .DQS_OE(DQS_OE)
);

//--- rtl/dbrw_pkg.sv
// Constants and types shared by the burst read/write engine and its storage.
package dbrw_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int MEM_AW = BANK_W + COL_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int CMD_W = 4 + BANK_W + ADDR_W;
  localparam int PIPE_DEPTH = 32;
  localparam int BURST_CHOP_BIT = 12;
  localparam int AUTO_PRECHARGE_BIT = 10;

  // Command codes as {select_n, row_strobe_n, column_strobe_n, write_enable_n}.
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_IDLE = 4'hf;

  // Mode register zero and one fields.
  localparam logic [BANK_W-1:0] BANK_MODE_ZERO = 3'h0;
  localparam logic [BANK_W-1:0] BANK_MODE_ONE = 3'h1;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CAS_LSB = 4;
  localparam int MR_ADD_LSB = 3;
  localparam logic [1:0] BL_OTF_EIGHT = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED_FOUR = 2'h2;
  localparam logic [1:0] BL_RESET = 2'h0;
  localparam logic [4:0] CAS_BASE = 5'h05;
  localparam logic [4:0] CAS_RESET = 5'h05;
  localparam logic [1:0] ADD_ZERO = 2'h0;
  localparam logic [1:0] ADD_CAS_MINUS_ONE = 2'h1;
  localparam logic [1:0] ADD_CAS_MINUS_TWO = 2'h2;
  localparam logic [1:0] ADD_RESET = 2'h0;

  // Beats per burst and write grace, counted in link clock edges.
  localparam logic [3:0] EDGES_EIGHT = 4'h8;
  localparam logic [3:0] EDGES_FOUR = 4'h4;
  localparam logic [4:0] WR_GRACE_EDGES = 5'h04;

  typedef struct packed {
    logic valid;
    logic wr;
    logic chop;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
  } dbrw_cmd_t;

  typedef enum logic [1:0] {
    DBRW_IDLE,
    DBRW_ACTIVE
  } dbrw_state_t;
endpackage

//--- rtl/dbrw_store.sv
// Byte-lane storage array with per-lane write mask and combinational read.
`timescale 1ns/100ps
module dbrw_store (
  input wire logic clock,
  dbrw_store_if.mem mem_bus
);
  import dbrw_pkg::*;

  // Each lane has its own array so a masked byte is never touched.
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [7:0] cells [MEM_DEPTH];
    always_ff @(posedge clock) begin
      if (mem_bus.wr_en && !mem_bus.wr_mask[l]) begin
        cells[mem_bus.wr_addr] <= mem_bus.wr_data[l*8 +: 8];
      end
    end
    assign mem_bus.rd_data[l*8 +: 8] = cells[mem_bus.rd_addr];
  end
endmodule

//--- rtl/dbrw_store_if.sv
// Interface between the burst engine and its byte-lane storage.
`timescale 1ns/100ps
interface dbrw_store_if;
  import dbrw_pkg::*;
  logic [MEM_AW-1:0] rd_addr;
  logic [DQ_W-1:0] rd_data;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [DQ_W-1:0] wr_data;
  logic [LANES-1:0] wr_mask;
  modport engine (
    output rd_addr,
    input rd_data,
    output wr_en,
    output wr_addr,
    output wr_data,
    output wr_mask
  );
  modport mem (
    input rd_addr,
    output rd_data,
    input wr_en,
    input wr_addr,
    input wr_data,
    input wr_mask
  );
endinterface

//--- rtl/dbrw_top.sv
// Memory-side burst read and write engine behind the command, strobe and data pins.
`timescale 1ns/100ps
// Summary of operation
// - Select bit low chops four, high eight unless burst field 10.
// - Select bit never forms column address.
// - On-the-fly chop when burst field 00/01.
// - Auto precharge does not affect burst length.
// - Release strobe/data at latency plus 4/2.
// - Read data edge-aligned to both strobe edges.
// - Data setup/hold violation corrupts only location.
// - Strobe violations corrupt only that write.
// - One mask per byte, ignored on reads.
module dbrw_top (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CK,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [dbrw_pkg::BANK_W-1:0] BA,
  input wire logic [dbrw_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dbrw_pkg::DQ_W-1:0] DQ_IN,
  output logic [dbrw_pkg::DQ_W-1:0] DQ_OUT,
  output logic DQ_OE,
  input wire logic DQS_IN,
  output logic DQS_OUT,
  output logic DQS_OE,
  input wire logic [dbrw_pkg::LANES-1:0] WRITE_BYTE_MASK
);
  import dbrw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; every pin is outside the system clock domain.
  logic ck_s1, ck_s2, ck_s3;
  logic [CMD_W-1:0] cmd_s1, cmd_s2;
  logic dqs_s1, dqs_s2, dqs_s3;
  logic [DQ_W-1:0] dq_s1, dq_s2;
  logic [LANES-1:0] mask_s1, mask_s2;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      cmd_s1 <= '1;
      cmd_s2 <= '1;
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_s3 <= 1'b0;
      dq_s1 <= '0;
      dq_s2 <= '0;
      mask_s1 <= '0;
      mask_s2 <= '0;
    end else begin
      ck_s1 <= CK;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      cmd_s1 <= {CS_N, RAS_N, CAS_N, WE_N, BA, ADDR};
      cmd_s2 <= cmd_s1;
      dqs_s1 <= DQS_IN;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
      dq_s1 <= DQ_IN;
      dq_s2 <= dq_s1;
      mask_s1 <= WRITE_BYTE_MASK;
      mask_s2 <= mask_s1;
    end
  end

  logic ck_rise, ck_edge;
  logic [3:0] cmd_code;
  logic [BANK_W-1:0] cmd_bank;
  logic [ADDR_W-1:0] cmd_addr;
  assign ck_rise = ck_s2 & ~ck_s3;
  assign ck_edge = ck_s2 ^ ck_s3;
  assign cmd_code = cmd_s2[CMD_W-1 -: 4];
  assign cmd_bank = cmd_s2[ADDR_W +: BANK_W];
  assign cmd_addr = cmd_s2[ADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers and latencies.
  logic [1:0] bl_reg, bl_next;
  logic [4:0] cas_reg, cas_next;
  logic [1:0] add_reg, add_next;
  logic [4:0] add_cycles, read_lat, rd_idx, wr_idx;

  always_comb begin
    bl_next = bl_reg;
    cas_next = cas_reg;
    add_next = add_reg;
    if (ck_rise && cmd_code == CMD_MRS) begin
      if (cmd_bank == BANK_MODE_ZERO) begin
        bl_next = cmd_addr[MR_BL_LSB +: 2];
        cas_next = CAS_BASE + {2'h0, cmd_addr[MR_CAS_LSB +: 3]};
      end else if (cmd_bank == BANK_MODE_ONE) begin
        add_next = cmd_addr[MR_ADD_LSB +: 2];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      bl_reg <= BL_RESET;
      cas_reg <= CAS_RESET;
      add_reg <= ADD_RESET;
    end else begin
      bl_reg <= bl_next;
      cas_reg <= cas_next;
      add_reg <= add_next;
    end
  end

  always_comb begin
    case (add_reg)
      ADD_CAS_MINUS_ONE: add_cycles = cas_reg - 5'h01;
      ADD_CAS_MINUS_TWO: add_cycles = cas_reg - 5'h02;
      default: add_cycles = 5'h00;
    endcase
  end
  assign read_lat = add_cycles + cas_reg;
  // The write window opens one link cycle ahead of the read latency.
  assign rd_idx = read_lat - 5'h01;
  assign wr_idx = read_lat - 5'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Column command decode and latency pipeline, shifted on link rising edges.
  dbrw_cmd_t new_cmd;
  dbrw_cmd_t pipe_reg [PIPE_DEPTH];
  dbrw_cmd_t pipe_next [PIPE_DEPTH];

  always_comb begin
    new_cmd = '0;
    if (ck_rise && (cmd_code == CMD_READ || cmd_code == CMD_WRITE)) begin
      new_cmd.valid = 1'b1;
      new_cmd.wr = (cmd_code == CMD_WRITE);
      // Auto precharge on the address line plays no part in the length.
      new_cmd.chop = (bl_reg == BL_FIXED_FOUR) ? 1'b1 : ~cmd_addr[BURST_CHOP_BIT];
      new_cmd.bank = cmd_bank;
      new_cmd.col = cmd_addr[COL_W-1:0];
    end
  end

  always_comb begin
    for (int i = 0; i < PIPE_DEPTH; i++) begin
      pipe_next[i] = pipe_reg[i];
    end
    if (ck_rise) begin
      pipe_next[0] = new_cmd;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_next[i] = pipe_reg[i-1];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_reg[i] <= '0;
      end
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  dbrw_cmd_t rd_slot, wr_slot;
  logic rd_hit, wr_hit;
  assign rd_slot = pipe_reg[rd_idx];
  assign wr_slot = pipe_reg[wr_idx];
  assign rd_hit = ck_rise && rd_slot.valid && !rd_slot.wr;
  assign wr_hit = ck_rise && wr_slot.valid && wr_slot.wr;

  function automatic logic [MEM_AW-1:0] beat_addr(input dbrw_cmd_t c, input logic [2:0] beat);
    logic [COL_W-1:0] col;
    col = c.col;
    if (c.chop) begin
      col[1:0] = col[1:0] + beat[1:0];
    end else begin
      col[2:0] = col[2:0] + beat;
    end
    return {c.bank, col};
  endfunction

  dbrw_store_if mem_bus ();
  dbrw_store u_store (
    .clock(CLOCK),
    .mem_bus(mem_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read engine: drives strobe and data on every link edge of the burst.
  dbrw_state_t rd_state_reg, rd_state_next;
  dbrw_cmd_t rd_cmd_reg, rd_cmd_next;
  logic [3:0] rd_beat_reg, rd_beat_next, rd_len;
  logic [DQ_W-1:0] dq_out_reg, dq_out_next;
  logic dq_oe_reg, dq_oe_next, dqs_out_reg, dqs_out_next, dqs_oe_reg, dqs_oe_next;

  assign rd_len = rd_cmd_reg.chop ? EDGES_FOUR : EDGES_EIGHT;
  assign mem_bus.rd_addr = rd_hit ? beat_addr(rd_slot, 3'h0) : beat_addr(rd_cmd_reg, rd_beat_reg[2:0]);

  always_comb begin
    rd_state_next = rd_state_reg;
    rd_cmd_next = rd_cmd_reg;
    rd_beat_next = rd_beat_reg;
    dq_out_next = dq_out_reg;
    dq_oe_next = dq_oe_reg;
    dqs_out_next = dqs_out_reg;
    dqs_oe_next = dqs_oe_reg;
    if (rd_hit) begin
      // A seamless follow-on read takes over at the release edge of the last.
      rd_state_next = DBRW_ACTIVE;
      rd_cmd_next = rd_slot;
      rd_beat_next = 4'h1;
      dq_out_next = mem_bus.rd_data;
      dqs_out_next = 1'b1;
      dq_oe_next = 1'b1;
      dqs_oe_next = 1'b1;
    end else begin
      case (rd_state_reg)
        DBRW_ACTIVE: begin
          if (ck_edge) begin
            if (rd_beat_reg == rd_len) begin
              rd_state_next = DBRW_IDLE;
              rd_beat_next = 4'h0;
              dq_oe_next = 1'b0;
              dqs_oe_next = 1'b0;
              dqs_out_next = 1'b0;
            end else begin
              dq_out_next = mem_bus.rd_data;
              dqs_out_next = ck_rise;
              rd_beat_next = rd_beat_reg + 4'h1;
            end
          end
        end
        default: begin
          rd_state_next = DBRW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rd_state_reg <= DBRW_IDLE;
      rd_cmd_reg <= '0;
      rd_beat_reg <= 4'h0;
      dq_out_reg <= '0;
      dq_oe_reg <= 1'b0;
      dqs_out_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
    end else begin
      rd_state_reg <= rd_state_next;
      rd_cmd_reg <= rd_cmd_next;
      rd_beat_reg <= rd_beat_next;
      dq_out_reg <= dq_out_next;
      dq_oe_reg <= dq_oe_next;
      dqs_out_reg <= dqs_out_next;
      dqs_oe_reg <= dqs_oe_next;
    end
  end

  assign DQ_OUT = dq_out_reg;
  assign DQ_OE = dq_oe_reg;
  assign DQS_OUT = dqs_out_reg;
  assign DQS_OE = dqs_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write engine. The window is timed by the link clock, not by the strobe,
  // so a missing, extra or misplaced strobe edge can only spoil this burst's
  // data and the engine always returns to idle.
  dbrw_state_t wr_state_reg, wr_state_next;
  dbrw_cmd_t wr_cmd_reg, wr_cmd_next;
  logic [3:0] wr_beat_reg, wr_beat_next, wr_len;
  logic [4:0] wr_timer_reg, wr_timer_next;
  logic dqs_edge, wr_accept;

  assign wr_len = wr_cmd_reg.chop ? EDGES_FOUR : EDGES_EIGHT;
  assign dqs_edge = (dqs_s2 ^ dqs_s3) & ~dqs_oe_reg;
  // The first beat must be a rising strobe edge, so the preamble is not data.
  // A strobe aligned to the opening clock rise is seen in that same cycle, so it is taken then too.
  assign wr_accept = dqs_edge && (wr_hit ? dqs_s2 : ((wr_state_reg == DBRW_ACTIVE) && (wr_beat_reg < wr_len)
                     && (wr_beat_reg != 4'h0 || dqs_s2)));

  assign mem_bus.wr_en = wr_accept;
  assign mem_bus.wr_addr = wr_hit ? beat_addr(wr_slot, 3'h0) : beat_addr(wr_cmd_reg, wr_beat_reg[2:0]);
  assign mem_bus.wr_data = dq_s2;
  assign mem_bus.wr_mask = mask_s2;

  always_comb begin
    wr_state_next = wr_state_reg;
    wr_cmd_next = wr_cmd_reg;
    wr_beat_next = wr_beat_reg;
    wr_timer_next = wr_timer_reg;
    if (wr_hit) begin
      wr_state_next = DBRW_ACTIVE;
      wr_cmd_next = wr_slot;
      wr_beat_next = wr_accept ? 4'h1 : 4'h0;
      wr_timer_next = 5'h00;
    end else begin
      case (wr_state_reg)
        DBRW_ACTIVE: begin
          if (wr_accept) begin
            wr_beat_next = wr_beat_reg + 4'h1;
          end
          if (ck_edge) begin
            if (wr_timer_reg == {1'b0, wr_len} + WR_GRACE_EDGES) begin
              wr_state_next = DBRW_IDLE;
            end else begin
              wr_timer_next = wr_timer_reg + 5'h01;
            end
          end
        end
        default: begin
          wr_state_next = DBRW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      wr_state_reg <= DBRW_IDLE;
      wr_cmd_reg <= '0;
      wr_beat_reg <= 4'h0;
      wr_timer_reg <= 5'h00;
    end else begin
      wr_state_reg <= wr_state_next;
      wr_cmd_reg <= wr_cmd_next;
      wr_beat_reg <= wr_beat_next;
      wr_timer_reg <= wr_timer_next;
    end
  end
endmodule
